// [rtl/fmbl_pkg.sv]
// Constants of the flash map and boot lock block: memory map, register offsets, commands.
// Assumes a 14-bit program and data address space of a 16-bit DSP core.
// Behaviour
// - Flash: 24-bit words, sectors 256, 256, 3584
// - Flash sectors consecutive in external program space
// - Decode vectors, program RAM, ROM monitor, reserved
// - Peripheral registers mapped at data 0x2000-0x20FF
// - Decode data RAM, core registers, reserved
// - Four 16-bit flash interface registers
// - Double external transfer costs extra cycle
// - Four nonvolatile scratch bytes, separate array
// - Erased scratch byte reads all zero
// - Locked device boots flash after reset
// - Locked device refuses external programmer, debugger
// - Unlock only by ROM routines from application
// - Full unlock erases flash, then clears lock
// - Keep unlock clears lock, flash untouched
// - Reset starts monitor; lock selects flash entry
package fmbl_pkg;
    localparam int          AW          = 14;
    localparam int          FAW         = 12;
    localparam int          FDW         = 24;
    localparam int          FWORDS      = 4096;
    localparam logic [13:0] PM_VEC_END  = 14'h002F;
    localparam logic [13:0] PM_RAM_END  = 14'h01FF;
    localparam logic [13:0] PM_ROM_LO   = 14'h0800;
    localparam logic [13:0] PM_ROM_HI   = 14'h17FF;
    localparam logic [13:0] PM_S0_LO    = 14'h2000;
    localparam logic [13:0] PM_S1_LO    = 14'h2100;
    localparam logic [13:0] PM_S2_LO    = 14'h2200;
    localparam logic [13:0] PM_FL_HI    = 14'h2FFF;
    localparam logic [13:0] DM_PER_LO   = 14'h2000;
    localparam logic [13:0] DM_PER_HI   = 14'h20FF;
    localparam logic [13:0] DM_RAM_LO   = 14'h3800;
    localparam logic [13:0] DM_RAM_HI   = 14'h39FF;
    localparam logic [13:0] DM_CORE_LO  = 14'h3C00;
    localparam logic [13:0] DM_CTRL     = 14'h20F0;
    localparam logic [13:0] DM_ADDR     = 14'h20F1;
    localparam logic [13:0] DM_DLO      = 14'h20F2;
    localparam logic [13:0] DM_DHI      = 14'h20F3;
    localparam logic [13:0] RESET_VEC   = 14'h0800;
    localparam logic [23:0] FL_ERASED   = 24'hFFFFFF;
    localparam logic [7:0]  SCR_ERASED  = 8'h00;
    localparam int          CTL_BUSY    = 8;
    localparam int          CTL_LOCK    = 9;
    localparam int          CTL_DONE    = 10;
    localparam logic [3:0]  CMD_NONE    = 4'h0;
    localparam logic [3:0]  CMD_READ    = 4'h1;
    localparam logic [3:0]  CMD_PROG    = 4'h2;
    localparam logic [3:0]  CMD_SRD     = 4'h3;
    localparam logic [3:0]  CMD_SPROG   = 4'h4;
    localparam logic [3:0]  CMD_SERASE  = 4'h5;
    localparam logic [3:0]  CMD_ERASE   = 4'h6;
    localparam logic [3:0]  CMD_LOCK    = 4'h7;
    localparam logic [3:0]  CMD_UNL_ERA = 4'h8;
    localparam logic [3:0]  CMD_UNL_KEEP = 4'h9;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ERASE = 3'b010,
        ST_UNL   = 3'b100
    } fmbl_state_t;
endpackage : fmbl_pkg

// [rtl/fmbl_top.sv]
// Flash map and boot lock: program/data decode, flash array, interface registers, scratch bytes, lock.
// Assumes the external command port is driven by serial logic on i_clk, so it is not synchronised.
`timescale 1ns/1ns
`default_nettype none
module fmbl_top (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_nv_blank_n,
    input  wire logic        i_ce,
    input  wire logic [13:0] i_pm_addr,
    input  wire logic        i_pm_rd,
    input  wire logic [13:0] i_dm_addr,
    input  wire logic        i_dm_rd,
    input  wire logic        i_dm_wr,
    input  wire logic [15:0] i_dm_wdata,
    input  wire logic        i_ext_req,
    input  wire logic [3:0]  i_ext_cmd,
    input  wire logic [11:0] i_ext_addr,
    input  wire logic [23:0] i_ext_wdata,
    output logic [23:0]      o_pm_rdata,
    output logic [15:0]      o_dm_rdata,
    output logic             o_sel_vec,
    output logic             o_sel_pram,
    output logic             o_sel_rom,
    output logic [2:0]       o_sel_sector,
    output logic             o_pm_rsvd,
    output logic             o_sel_periph,
    output logic             o_sel_dram,
    output logic             o_sel_core,
    output logic             o_dm_rsvd,
    output logic             o_ext_stall,
    output logic             o_ext_ack,
    output logic             o_ext_refused,
    output logic [23:0]      o_ext_rdata,
    output logic             o_boot_flash,
    output logic [13:0]      o_reset_vec,
    output logic [13:0]      o_boot_target
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire        pm_fl  = (i_pm_addr >= fmbl_pkg::PM_S0_LO) && (i_pm_addr <= fmbl_pkg::PM_FL_HI);
    wire        pm_rom = (i_pm_addr >= fmbl_pkg::PM_ROM_LO) && (i_pm_addr <= fmbl_pkg::PM_ROM_HI);
    wire [11:0] pm_fa  = i_pm_addr[11:0];
    wire        dm_per = (i_dm_addr >= fmbl_pkg::DM_PER_LO) && (i_dm_addr <= fmbl_pkg::DM_PER_HI);
    wire        dm_ram = (i_dm_addr >= fmbl_pkg::DM_RAM_LO) && (i_dm_addr <= fmbl_pkg::DM_RAM_HI);
    wire        dm_cor = i_dm_addr >= fmbl_pkg::DM_CORE_LO;
    assign o_sel_vec    = i_pm_addr <= fmbl_pkg::PM_VEC_END;
    assign o_sel_pram   = !o_sel_vec && (i_pm_addr <= fmbl_pkg::PM_RAM_END);
    assign o_sel_rom    = pm_rom;
    assign o_sel_sector[0] = pm_fl && (i_pm_addr < fmbl_pkg::PM_S1_LO);
    assign o_sel_sector[1] = (i_pm_addr >= fmbl_pkg::PM_S1_LO) && (i_pm_addr < fmbl_pkg::PM_S2_LO);
    assign o_sel_sector[2] = (i_pm_addr >= fmbl_pkg::PM_S2_LO) && pm_fl;
    assign o_pm_rsvd    = !(o_sel_vec || o_sel_pram || pm_rom || pm_fl);
    assign o_sel_periph = dm_per;
    assign o_sel_dram   = dm_ram;
    assign o_sel_core   = dm_cor;
    assign o_dm_rsvd    = !(dm_per || dm_ram || dm_cor);
    // The flash shares one external bus, so a flash fetch and a flash register access collide.
    wire dm_ext = (i_dm_rd || i_dm_wr) && dm_per;
    assign o_ext_stall  = i_pm_rd && pm_fl && dm_ext;
    wire dm_go  = i_ce && !o_ext_stall;
    wire wr_ctl = dm_go && i_dm_wr && (i_dm_addr == fmbl_pkg::DM_CTRL);

    // ------------------------------------------------------------
    // Nonvolatile storage
    // ------------------------------------------------------------
    logic [23:0] flash_mem [0:fmbl_pkg::FWORDS-1];
    wire  [7:0]  scr_r [0:3];
    logic        lock_r;
    logic [15:0] ctl_r;
    logic [15:0] adr_r;
    logic [15:0] dlo_r;
    logic [15:0] dhi_r;
    logic        rom_exec_r;
    logic [11:0] era_cnt_r;
    fmbl_pkg::fmbl_state_t st_r;
    fmbl_pkg::fmbl_state_t st_nxt;

    wire [3:0]  ccmd    = i_dm_wdata[3:0];
    wire        idle    = st_r == fmbl_pkg::ST_IDLE;
    // Unlock is honoured only from code fetched out of ROM, so no outside path can reach it.
    wire        unl_ok  = wr_ctl && idle && rom_exec_r;
    wire        unl_era = unl_ok && (ccmd == fmbl_pkg::CMD_UNL_ERA);
    wire        unl_kp  = unl_ok && (ccmd == fmbl_pkg::CMD_UNL_KEEP);
    wire        ext_go  = i_ce && i_ext_req && idle && !lock_r;
    wire        ext_bad = i_ce && i_ext_req && !ext_go;
    wire        c_prog  = wr_ctl && idle && (ccmd == fmbl_pkg::CMD_PROG);
    wire        c_read  = wr_ctl && idle && (ccmd == fmbl_pkg::CMD_READ);
    wire        c_srd   = wr_ctl && idle && (ccmd == fmbl_pkg::CMD_SRD);
    wire        e_prog  = ext_go && (i_ext_cmd == fmbl_pkg::CMD_PROG);
    wire        e_erase = ext_go && (i_ext_cmd == fmbl_pkg::CMD_ERASE);
    wire        e_sprog = ext_go && (i_ext_cmd == fmbl_pkg::CMD_SPROG);
    wire        e_serase = ext_go && (i_ext_cmd == fmbl_pkg::CMD_SERASE);
    wire        e_lock  = ext_go && (i_ext_cmd == fmbl_pkg::CMD_LOCK);
    wire        era_end = (st_r == fmbl_pkg::ST_ERASE) && (era_cnt_r == 12'hFFF);
    wire [11:0] c_fa    = adr_r[11:0];
    wire [1:0]  e_sa    = i_ext_addr[1:0];

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            fmbl_pkg::ST_IDLE: begin
                if (unl_era || e_erase) begin
                    st_nxt = fmbl_pkg::ST_ERASE;
                end
            end
            fmbl_pkg::ST_ERASE: begin
                if (era_end) begin
                    st_nxt = fmbl_pkg::ST_UNL;
                end
            end
            fmbl_pkg::ST_UNL: st_nxt = fmbl_pkg::ST_IDLE;
            default: st_nxt = fmbl_pkg::ST_IDLE;
        endcase
    end

    // Erase walks one word per cycle; the array has no reset, being nonvolatile.
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (st_r == fmbl_pkg::ST_ERASE) begin
                flash_mem[era_cnt_r] <= fmbl_pkg::FL_ERASED;
            end else if (c_prog) begin
                flash_mem[c_fa] <= {dhi_r, dlo_r[7:0]};
            end else if (e_prog) begin
                flash_mem[i_ext_addr] <= i_ext_wdata;
            end
        end
    end

    // The lock and scratch cells survive core reset; of the two resets only the blank-device init clears them.
    always_ff @(posedge i_clk or negedge i_nv_blank_n) begin
        if (!i_nv_blank_n) begin
            lock_r <= 1'b0;
        end else if (i_ce) begin
            if (unl_kp || (st_r == fmbl_pkg::ST_UNL)) begin
                lock_r <= 1'b0;
            end else if (e_lock) begin
                lock_r <= 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_scr
            logic [7:0] cell_r;
            always_ff @(posedge i_clk or negedge i_nv_blank_n) begin
                if (!i_nv_blank_n) begin
                    cell_r <= fmbl_pkg::SCR_ERASED;
                end else if (i_ce && (e_sa == 2'(g))) begin
                    if (e_serase) begin
                        cell_r <= fmbl_pkg::SCR_ERASED;
                    end else if (e_sprog) begin
                        cell_r <= i_ext_wdata[7:0];
                    end
                end
            end
            assign scr_r[g] = cell_r;
        end
    endgenerate

    // ------------------------------------------------------------
    // Interface registers and sequencing
    // ------------------------------------------------------------
    localparam int CTL_DONE_I = fmbl_pkg::CTL_DONE;
    wire [15:0] ctl_rd = {5'h00, ctl_r[CTL_DONE_I], lock_r, !idle, 4'h0, ctl_r[3:0]};
    wire [15:0] dm_sel_rd = (i_dm_addr == fmbl_pkg::DM_CTRL) ? ctl_rd :
                            (i_dm_addr == fmbl_pkg::DM_ADDR) ? adr_r :
                            (i_dm_addr == fmbl_pkg::DM_DLO)  ? dlo_r :
                            (i_dm_addr == fmbl_pkg::DM_DHI)  ? dhi_r : 16'h0000;
    wire [23:0] c_word = flash_mem[c_fa];
    wire [23:0] p_word = flash_mem[pm_fa];
    wire [23:0] e_word = (i_ext_cmd == fmbl_pkg::CMD_SRD) ? {16'h0000, scr_r[e_sa]} : flash_mem[i_ext_addr];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r       <= fmbl_pkg::ST_IDLE;
            era_cnt_r  <= 12'h000;
            ctl_r      <= 16'h0000;
            adr_r      <= 16'h0000;
            dlo_r      <= 16'h0000;
            dhi_r      <= 16'h0000;
            rom_exec_r <= 1'b0;
            o_pm_rdata <= 24'h000000;
            o_dm_rdata <= 16'h0000;
            o_ext_ack  <= 1'b0;
            o_ext_refused <= 1'b0;
            o_ext_rdata <= 24'h000000;
        end else if (i_ce) begin
            st_r       <= st_nxt;
            era_cnt_r  <= (st_r == fmbl_pkg::ST_ERASE) ? era_cnt_r + 12'h001 : 12'h000;
            o_ext_ack  <= ext_go;
            o_ext_refused <= ext_bad;
            if (ext_go) begin
                o_ext_rdata <= e_word;
            end
            if (i_pm_rd) begin
                rom_exec_r <= pm_rom;
                o_pm_rdata <= pm_fl ? p_word : 24'h000000;
            end
            if (dm_go && i_dm_rd) begin
                o_dm_rdata <= dm_per ? dm_sel_rd : 16'h0000;
            end
            if (wr_ctl) begin
                ctl_r[3:0] <= ccmd;
            end
            ctl_r[CTL_DONE_I] <= (st_r == fmbl_pkg::ST_UNL) || unl_kp || (ctl_r[CTL_DONE_I] && !wr_ctl);
            if (dm_go && i_dm_wr && (i_dm_addr == fmbl_pkg::DM_ADDR)) begin
                adr_r <= i_dm_wdata;
            end
            if (c_read) begin
                dhi_r <= c_word[23:8];
                dlo_r <= {8'h00, c_word[7:0]};
            end else if (c_srd) begin
                dlo_r <= {8'h00, scr_r[adr_r[1:0]]};
            end else if (dm_go && i_dm_wr && (i_dm_addr == fmbl_pkg::DM_DLO)) begin
                dlo_r <= i_dm_wdata;
            end
            if (!c_read && dm_go && i_dm_wr && (i_dm_addr == fmbl_pkg::DM_DHI)) begin
                dhi_r <= i_dm_wdata;
            end
        end
    end

    // The monitor always starts at the ROM vector and branches on the lock.
    assign o_reset_vec   = fmbl_pkg::RESET_VEC;
    assign o_boot_flash  = lock_r;
    assign o_boot_target = lock_r ? fmbl_pkg::PM_S2_LO : fmbl_pkg::RESET_VEC;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !i_nv_blank_n);

    chk_lock_refuse: assert property (i_ce && i_ext_req && lock_r |=> o_ext_refused && !o_ext_ack)
        else $error("external request accepted while locked");
    chk_lock_nodata: assert property (lock_r && i_ce |=> $stable(o_ext_rdata))
        else $error("external data changed while locked");
    chk_lock_noset: assert property (!lock_r && !(e_lock && i_ce) |=> !lock_r)
        else $error("lock set without lock command");
    chk_keep_unlock: assert property (unl_kp && i_ce |=> !lock_r && idle)
        else $error("keep unlock did not clear lock");
    chk_erase_before: assert property (st_r == fmbl_pkg::ST_ERASE && i_ce |=> $stable(lock_r))
        else $error("lock cleared before erase finished");
    chk_erase_end: assert property (era_end && i_ce |=> st_r == fmbl_pkg::ST_UNL ##1 !lock_r)
        else $error("erase end did not unlock");
    chk_unlock_rom: assert property (wr_ctl && idle && !rom_exec_r |=> $stable(lock_r) || $past(e_lock))
        else $error("unlock from outside rom");
    chk_boot_sel: assert property (o_boot_target == (lock_r ? 14'h2200 : 14'h0800))
        else $error("wrong boot target");
    chk_stall_both: assert property (i_pm_rd && pm_fl && i_dm_rd && dm_per |-> o_ext_stall)
        else $error("double external access not stalled");
    chk_sector_one: assert property (pm_fl |-> $onehot(o_sel_sector))
        else $error("sector decode not one-hot");
    chk_ext_ack: assert property (ext_go |=> o_ext_ack ##1 !o_ext_ack || $past(ext_go))
        else $error("accepted request not acknowledged");

    cov_lock: cover property (e_lock && i_ce ##1 lock_r);
    cov_refuse: cover property (o_ext_refused);
    cov_full_unlock: cover property (st_r == fmbl_pkg::ST_UNL);
    cov_stall: cover property (o_ext_stall);
endmodule : fmbl_top
`default_nettype wire

// [tb/fmbl_core_model.sv]
// Behavioural model of the DSP core that drives the program and data buses of the flash map block.
// Assumes one clock shared with the block; every bus change is made at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module fmbl_core_model (
    input  wire logic        i_clk,
    input  wire logic        i_general_purpose_pin,
    input  wire logic [23:0] i_pm_rdata,
    input  wire logic [15:0] i_dm_rdata,
    output logic [13:0]      o_pm_addr,
    output logic             o_pm_rd,
    output logic [13:0]      o_dm_addr,
    output logic             o_dm_rd,
    output logic             o_dm_wr,
    output logic [15:0]      o_dm_wdata
);
    initial begin
        o_pm_addr  = 14'h0000;
        o_pm_rd    = 1'b0;
        o_dm_addr  = 14'h0000;
        o_dm_rd    = 1'b0;
        o_dm_wr    = 1'b0;
        o_dm_wdata = 16'h0000;
    end

    task automatic set_addr(input logic [13:0] pa, input logic [13:0] da);
        @(negedge i_clk);
        o_pm_addr = pa;
        o_dm_addr = da;
    endtask : set_addr

    task automatic pm_read(input logic [13:0] a, output logic [23:0] d);
        @(negedge i_clk);
        o_pm_addr = a;
        o_pm_rd   = 1'b1;
        @(negedge i_clk);
        o_pm_rd = 1'b0;
        d       = i_pm_rdata;
    endtask : pm_read

    task automatic dm_write(input logic [13:0] a, input logic [15:0] w);
        @(negedge i_clk);
        o_dm_addr  = a;
        o_dm_wdata = w;
        o_dm_wr    = 1'b1;
        @(negedge i_clk);
        o_dm_wr    = 1'b0;
        o_dm_wdata = ~w;
    endtask : dm_write

    task automatic dm_read(input logic [13:0] a, output logic [15:0] d);
        @(negedge i_clk);
        o_dm_addr = a;
        o_dm_rd   = 1'b1;
        @(negedge i_clk);
        o_dm_rd = 1'b0;
        d       = i_dm_rdata;
    endtask : dm_read

    // Holds a flash fetch and a register read in one cycle to provoke the shared-bus stall.
    task automatic dual_on(input logic [13:0] pa, input logic [13:0] da);
        @(negedge i_clk);
        o_pm_addr = pa;
        o_pm_rd   = 1'b1;
        o_dm_addr = da;
        o_dm_rd   = 1'b1;
    endtask : dual_on

    task automatic bus_idle;
        @(negedge i_clk);
        o_pm_rd = 1'b0;
        o_dm_rd = 1'b0;
    endtask : bus_idle

    // ------------------------------------------------------------------
    // Resident routine call
    // ------------------------------------------------------------------
    // Interface registers are written here from code running in the monitor area; the application can write them too, but only monitor code unlocks.
    task automatic rom_call(input logic [3:0] cmd, input logic [15:0] a);
        logic [23:0] dummy;
        if ((cmd == fmbl_pkg::CMD_UNL_ERA || cmd == fmbl_pkg::CMD_UNL_KEEP) && !i_general_purpose_pin) begin
            return;
        end
        pm_read(14'h0900, dummy);
        dm_write(fmbl_pkg::DM_ADDR, a);
        dm_write(fmbl_pkg::DM_CTRL, {12'h000, cmd});
    endtask : rom_call
endmodule : fmbl_core_model
`default_nettype wire

// [tb/flash_memory_map_boot_lock_tb.sv]
// Self-checking bench for the flash map and boot lock block with a core model on its buses.
// Assumes the external programmer path is driven directly by the bench at falling edges.
`timescale 1ns/1ns
`default_nettype none
module flash_memory_map_boot_lock_tb;
    logic clk = 1'b0, rst_n = 1'b0, blank_n = 1'b0, gp_pin = 1'b0;
    logic ext_req = 1'b0;
    logic ce = 1'b1;
    logic [3:0] ext_cmd = 4'h0;
    logic [11:0] ext_addr = 12'h000;
    logic [23:0] ext_wdata = 24'h000000;
    logic [13:0] pm_addr, dm_addr;
    logic pm_rd, dm_rd, dm_wr;
    logic [15:0] dm_wdata, dm_rdata;
    logic [23:0] pm_rdata, ext_rdata;
    logic sel_vec, sel_pram, sel_rom, pm_rsvd, sel_periph, sel_dram, sel_core, dm_rsvd;
    logic ext_stall, ext_ack, ext_refused, boot_flash;
    logic [2:0] sel_sector;
    logic [13:0] reset_vec, boot_target;
    int fails = 0, num_checks = 0;
    logic ack, rfs;
    logic [23:0] rd;
    logic [15:0] dr;

    initial forever #4 clk = ~clk;

    fmbl_top i_fmbl_top (.i_clk(clk), .i_rst_n(rst_n), .i_nv_blank_n(blank_n), .i_ce(ce),
        .i_pm_addr(pm_addr), .i_pm_rd(pm_rd), .i_dm_addr(dm_addr), .i_dm_rd(dm_rd), .i_dm_wr(dm_wr),
        .i_dm_wdata(dm_wdata), .i_ext_req(ext_req), .i_ext_cmd(ext_cmd), .i_ext_addr(ext_addr),
        .i_ext_wdata(ext_wdata), .o_pm_rdata(pm_rdata), .o_dm_rdata(dm_rdata), .o_sel_vec(sel_vec),
        .o_sel_pram(sel_pram), .o_sel_rom(sel_rom), .o_sel_sector(sel_sector), .o_pm_rsvd(pm_rsvd),
        .o_sel_periph(sel_periph), .o_sel_dram(sel_dram), .o_sel_core(sel_core), .o_dm_rsvd(dm_rsvd),
        .o_ext_stall(ext_stall), .o_ext_ack(ext_ack), .o_ext_refused(ext_refused), .o_ext_rdata(ext_rdata),
        .o_boot_flash(boot_flash), .o_reset_vec(reset_vec), .o_boot_target(boot_target));

    fmbl_core_model i_fmbl_core_model (.i_clk(clk), .i_general_purpose_pin(gp_pin), .i_pm_rdata(pm_rdata),
        .i_dm_rdata(dm_rdata), .o_pm_addr(pm_addr), .o_pm_rd(pm_rd), .o_dm_addr(dm_addr), .o_dm_rd(dm_rd),
        .o_dm_wr(dm_wr), .o_dm_wdata(dm_wdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    // The command lines are scrambled after each pulse so a stale value cannot pass for a live one.
    task automatic ext(input logic [3:0] c, input logic [11:0] a, input logic [23:0] w);
        @(negedge clk);
        {ext_req, ext_cmd, ext_addr, ext_wdata} = {1'b1, c, a, w};
        @(negedge clk);
        {ext_req, ext_cmd, ext_addr, ext_wdata} = {1'b0, ~c, ~a, ~w};
        {ack, rfs, rd} = {ext_ack, ext_refused, ext_rdata};
    endtask : ext

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_decode;
        logic [13:0] pa [16] = '{14'h0000, 14'h002F, 14'h0030, 14'h01FF, 14'h0200, 14'h07FF, 14'h0800, 14'h17FF,
                                 14'h1800, 14'h2000, 14'h20FF, 14'h2100, 14'h21FF, 14'h2200, 14'h2FFF, 14'h3000};
        logic [6:0]  pe [16] = '{7'h40, 7'h40, 7'h20, 7'h20, 7'h01, 7'h01, 7'h10, 7'h10,
                                 7'h01, 7'h02, 7'h02, 7'h04, 7'h04, 7'h08, 7'h08, 7'h01};
        logic [13:0] da [12] = '{14'h0000, 14'h1FFF, 14'h2000, 14'h20FF, 14'h2100, 14'h37FF, 14'h3800,
                                 14'h39FF, 14'h3A00, 14'h3BFF, 14'h3C00, 14'h3FFF};
        logic [3:0]  de [12] = '{4'h1, 4'h1, 4'h8, 4'h8, 4'h1, 4'h1, 4'h4, 4'h4, 4'h1, 4'h1, 4'h2, 4'h2};
        for (int i = 0; i < 16; i++) begin
            i_fmbl_core_model.set_addr(pa[i], da[i % 12]);
            #1;
            check({sel_vec, sel_pram, sel_rom, sel_sector, pm_rsvd}, pe[i]);
            if (i < 12) check({sel_periph, sel_dram, sel_core, dm_rsvd}, de[i]);
        end
        $display("test decode done");
    endtask : t_decode

    task automatic t_flash;
        logic [11:0] fa [4] = '{12'h0FF, 12'h100, 12'h200, 12'hFFF};
        ce = 1'b0;
        ext(fmbl_pkg::CMD_PROG, 12'h0FF, 24'h123456);
        check({ack, rfs}, 2'b00);
        ce = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ext(fmbl_pkg::CMD_PROG, fa[i], {12'hA5C, fa[i]});
            check({ack, rfs}, 2'b10);
            ext(fmbl_pkg::CMD_READ, fa[i], 24'h000000);
            check(rd, {12'hA5C, fa[i]});
            i_fmbl_core_model.pm_read(14'h2000 + {2'b00, fa[i]}, rd);
            check(rd, {12'hA5C, fa[i]});
        end
        $display("test flash done");
    endtask : t_flash

    task automatic t_scratch;
        for (int i = 0; i < 4; i++) begin
            ext(fmbl_pkg::CMD_SERASE, 12'(i), 24'h000000);
            ext(fmbl_pkg::CMD_SRD, 12'(i), 24'h000000);
            check(rd[7:0], fmbl_pkg::SCR_ERASED);
        end
        ext(fmbl_pkg::CMD_PROG, 12'h002, 24'hA5C002);
        ext(fmbl_pkg::CMD_SPROG, 12'h002, 24'h00005A);
        i_fmbl_core_model.rom_call(fmbl_pkg::CMD_SRD, 16'h0002);
        repeat (2) @(negedge clk);
        i_fmbl_core_model.dm_read(fmbl_pkg::DM_DLO, dr);
        check(dr[7:0], 8'h5A);
        ext(fmbl_pkg::CMD_READ, 12'h002, 24'h000000);
        check(rd, 24'hA5C002);
        $display("test scratch done");
    endtask : t_scratch

    task automatic t_regs;
        i_fmbl_core_model.rom_call(fmbl_pkg::CMD_READ, 16'h0200);
        repeat (2) @(negedge clk);
        i_fmbl_core_model.dm_read(fmbl_pkg::DM_DHI, dr);
        check(dr, 16'hA5C2);
        i_fmbl_core_model.dm_read(fmbl_pkg::DM_DLO, dr);
        check(dr[7:0], 8'h00);
        i_fmbl_core_model.dual_on(14'h2200, fmbl_pkg::DM_ADDR);
        #1;
        check(ext_stall, 1'b1);
        i_fmbl_core_model.bus_idle();
        check(dm_rdata, 16'h0000);
        $display("test registers done");
    endtask : t_regs

    task automatic t_lock;
        ext(fmbl_pkg::CMD_LOCK, 12'h0FF, 24'h000000);
        check({boot_flash, boot_target}, {1'b1, 14'h2200});
        ext(fmbl_pkg::CMD_READ, 12'h200, 24'h000000);
        check({ack, rfs, rd}, {1'b0, 1'b1, 24'hA5C0FF});
        ext(fmbl_pkg::CMD_PROG, 12'h200, 24'h123456);
        check({ack, rfs}, 2'b01);
        @(negedge clk) rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        check({boot_flash, reset_vec, boot_target}, {1'b1, 14'h0800, 14'h2200});
        i_fmbl_core_model.pm_read(14'h2200, rd);
        check(rd, 24'hA5C200);
        gp_pin = 1'b1;
        i_fmbl_core_model.dm_write(fmbl_pkg::DM_CTRL, {12'h000, fmbl_pkg::CMD_UNL_KEEP});
        repeat (3) @(negedge clk);
        check(boot_flash, 1'b1);
        i_fmbl_core_model.rom_call(fmbl_pkg::CMD_UNL_KEEP, 16'h0000);
        repeat (2) @(negedge clk);
        i_fmbl_core_model.dm_read(fmbl_pkg::DM_CTRL, dr);
        check({boot_flash, dr[fmbl_pkg::CTL_LOCK], dr[fmbl_pkg::CTL_DONE]}, 3'b001);
        ext(fmbl_pkg::CMD_READ, 12'h200, 24'h000000);
        check({ack, rd}, {1'b1, 24'hA5C200});
        $display("test lock done");
    endtask : t_lock

    task automatic t_unlock_erase;
        int n;
        ext(fmbl_pkg::CMD_LOCK, 12'h000, 24'h000000);
        i_fmbl_core_model.rom_call(fmbl_pkg::CMD_UNL_ERA, 16'h0000);
        for (n = 0; n < 5000 && boot_flash !== 1'b0; n++) @(negedge clk);
        if (n == 5000) begin
            fails++;
            report_and_stop();
        end
        check(n > 4000, 1'b1);
        ext(fmbl_pkg::CMD_READ, 12'h200, 24'h000000);
        check({ack, rd}, {1'b1, fmbl_pkg::FL_ERASED});
        ext(fmbl_pkg::CMD_READ, 12'h0FF, 24'h000000);
        check(rd, fmbl_pkg::FL_ERASED);
        ext(fmbl_pkg::CMD_PROG, 12'h100, 24'h00A5A5);
        ext(fmbl_pkg::CMD_ERASE, 12'h000, 24'h000000);
        ext(fmbl_pkg::CMD_READ, 12'h100, 24'h000000);
        check({ack, rfs}, 2'b01);
        repeat (4100) @(negedge clk);
        ext(fmbl_pkg::CMD_READ, 12'h100, 24'h000000);
        check({ack, rd}, {1'b1, fmbl_pkg::FL_ERASED});
        $display("test unlock erase done");
    endtask : t_unlock_erase

    initial begin
        repeat (5) @(negedge clk);
        {rst_n, blank_n} = 2'b11;
        t_decode();
        t_flash();
        t_scratch();
        t_regs();
        t_lock();
        t_unlock_erase();
        report_and_stop();
    end
endmodule : flash_memory_map_boot_lock_tb
`default_nettype wire
